// *** rtl/l2ffe_engine.v ***
// layer-2 forwarding engine: classify, learn, filter, forward, age
`timescale 1ns/1ps
`include "l2ffe_defines.vh"
`default_nettype none
module l2ffe_engine #(
  parameter integer PORTS = 8,
  parameter integer PW = 3,
  parameter integer ENTRIES = 16,
  parameter integer AGE_TICK_CYC = `L2FFE_AGE_TICK_CYC
) (
  input wire core_clk,
  input wire rst,
  input wire frameValid,
  input wire [PW-1:0] rxPort,
  input wire [47:0] dstMac,
  input wire [47:0] srcMac,
  input wire frameTagged,
  input wire [11:0] tagVid,
  input wire [PORTS*12-1:0] portDefaultVid,
  input wire [PORTS-1:0] portForwarding,
  input wire [PORTS*2-1:0] portRole,
  input wire treeStable,
  input wire [PORTS*12-1:0] portVlanId,
  input wire [PORTS-1:0] portVlanMember,
  input wire [PORTS-1:0] portTaggedMember,
  input wire [47:0] filterMac0,
  input wire [47:0] filterMac1,
  input wire [1:0] filterEnable,
  input wire [7:0] agePeriod,
  input wire [15:0] maxAgeTicks,
  input wire rootHelloSeen,
  output reg busy,
  output reg resultValid,
  output reg [PORTS-1:0] egressMask,
  output reg [PORTS-1:0] egressTagMask,
  output reg [11:0] frameVid,
  output reg frameDropped,
  output reg bpduValid,
  output reg [PW-1:0] bpduPort,
  output reg rootTimeout,
  output reg learnSkipped
);
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_LEARN = 5'h02;
  localparam [4:0] S_FILTER = 5'h04;
  localparam [4:0] S_FORWARD = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  reg [4:0] state;
  reg [PW-1:0] curPort;
  reg [47:0] curDst;
  reg [47:0] curSrc;
  reg [11:0] curVid;
  reg curMulti;
  reg [PW-1:0] dstPort;
  reg dstKnown;
  reg dropFlag;

  reg tblValid [0:ENTRIES-1];
  reg [47:0] tblMac [0:ENTRIES-1];
  reg [11:0] tblVid [0:ENTRIES-1];
  reg [PW-1:0] tblPort [0:ENTRIES-1];
  reg [7:0] tblAge [0:ENTRIES-1];

  // synchronised pin-level input rootHelloSeen and its edge detect
  reg helloMeta;
  reg helloSync;
  reg helloPrev;

  wire ageTick;
  l2ffe_tick_div #(.DIV(AGE_TICK_CYC)) ageDiv (
    .core_clk(core_clk),
    .rst(rst),
    .tick(ageTick)
  );

  // table search for source and destination pairs
  reg srcHit;
  reg [31:0] srcIdx;
  reg freeHit;
  reg [31:0] freeIdx;
  reg dstHit;
  reg [31:0] dstIdx;
  integer i;
  always @* begin
    srcHit = 1'b0;
    srcIdx = 32'h0;
    freeHit = 1'b0;
    freeIdx = 32'h0;
    dstHit = 1'b0;
    dstIdx = 32'h0;
    for (i = ENTRIES - 1; i >= 0; i = i - 1) begin
      if (tblValid[i] && tblMac[i] == curSrc && tblVid[i] == curVid) begin
        srcHit = 1'b1;
        srcIdx = i;
      end
      if (tblValid[i] && tblMac[i] == curDst && tblVid[i] == curVid) begin
        dstHit = 1'b1;
        dstIdx = i;
      end
      if (!tblValid[i]) begin
        freeHit = 1'b1;
        freeIdx = i;
      end
    end
  end

  // port may pass traffic: spanning-tree state and, once settled, role
  function portOpen;
    input [PW-1:0] p;
    input [PORTS-1:0] fwd;
    input [PORTS*2-1:0] role;
    input stable;
    reg [1:0] r;
    begin
      r = role[p*2 +: 2];
      portOpen = fwd[p] && (!stable || r == `L2FFE_ROLE_ROOT || r == `L2FFE_ROLE_DESIG); // R06 R17
    end
  endfunction

  reg isFiltered;
  always @* begin
    isFiltered = 1'b0;
    if (filterEnable[0] && (curSrc == filterMac0 || (!curMulti && curDst == filterMac0))) begin
      isFiltered = 1'b1; // R07
    end
    if (filterEnable[1] && (curSrc == filterMac1 || (!curMulti && curDst == filterMac1))) begin
      isFiltered = 1'b1; // R07
    end
  end

  // flood set: VLAN members except the source, restricted to open ports
  reg [PORTS-1:0] floodMask;
  reg [PORTS-1:0] tagMask;
  integer p;
  always @* begin
    floodMask = {PORTS{1'b0}};
    tagMask = {PORTS{1'b0}};
    for (p = 0; p < PORTS; p = p + 1) begin
      if (portVlanMember[p] && portVlanId[p*12 +: 12] == curVid && p != curPort &&
          portOpen(p[PW-1:0], portForwarding, portRole, treeStable)) begin
        floodMask[p] = 1'b1; // R09 R15
      end
      tagMask[p] = portTaggedMember[p]; // R11
    end
  end

  integer k;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      curPort <= {PW{1'b0}};
      curDst <= 48'h0;
      curSrc <= 48'h0;
      curVid <= 12'h000;
      curMulti <= 1'b0;
      dstPort <= {PW{1'b0}};
      dstKnown <= 1'b0;
      dropFlag <= 1'b0;
      busy <= 1'b0;
      resultValid <= 1'b0;
      egressMask <= {PORTS{1'b0}};
      egressTagMask <= {PORTS{1'b0}};
      frameVid <= 12'h000;
      frameDropped <= 1'b0;
      bpduValid <= 1'b0;
      bpduPort <= {PW{1'b0}};
      learnSkipped <= 1'b0;
      for (k = 0; k < ENTRIES; k = k + 1) begin
        tblValid[k] <= 1'b0;
        tblMac[k] <= 48'h0;
        tblVid[k] <= 12'h000;
        tblPort[k] <= {PW{1'b0}};
        tblAge[k] <= `L2FFE_AGE_RESET;
      end
    end else begin
      resultValid <= 1'b0;
      bpduValid <= 1'b0;
      learnSkipped <= 1'b0;
      // aging runs beside the frame pipeline; learning refresh wins
      if (ageTick) begin
        for (k = 0; k < ENTRIES; k = k + 1) begin
          if (tblValid[k]) begin
            if (tblAge[k] >= agePeriod) begin
              tblValid[k] <= 1'b0; // R12 R18
            end else begin
              tblAge[k] <= tblAge[k] + 8'h01; // R18
            end
          end
        end
      end
      case (state)
        S_IDLE: begin
          if (frameValid) begin
            if (dstMac == `L2FFE_BPDU_DA) begin
              bpduValid <= 1'b1; // R13
              bpduPort <= rxPort; // R13
            end else begin
              curPort <= rxPort;
              curDst <= dstMac;
              curSrc <= srcMac;
              curMulti <= dstMac[40];
              if (frameTagged) begin
                curVid <= tagVid; // R02
              end else begin
                curVid <= portDefaultVid[rxPort*12 +: 12]; // R01
              end
              busy <= 1'b1;
              state <= S_LEARN; // R03
            end
          end
        end
        S_LEARN: begin
          if (srcHit) begin
            tblPort[srcIdx] <= curPort; // R05
            tblAge[srcIdx] <= `L2FFE_AGE_RESET; // R18
            tblValid[srcIdx] <= 1'b1;
          end else if (freeHit) begin
            tblValid[freeIdx] <= 1'b1; // R04
            tblMac[freeIdx] <= curSrc; // R04
            tblVid[freeIdx] <= curVid; // R04
            tblPort[freeIdx] <= curPort; // R04
            tblAge[freeIdx] <= `L2FFE_AGE_RESET;
          end else begin
            learnSkipped <= 1'b1; // R19
          end
          state <= S_FILTER; // R03
        end
        S_FILTER: begin
          dstKnown <= !curMulti && dstHit; // R14
          dstPort <= tblPort[dstIdx];
          dropFlag <= isFiltered ||
            !portOpen(curPort, portForwarding, portRole, treeStable) ||
            (!curMulti && dstHit && (tblPort[dstIdx] == curPort ||
            !portOpen(tblPort[dstIdx], portForwarding, portRole, treeStable))); // R06 R08 R14
          state <= S_FORWARD; // R03
        end
        S_FORWARD: begin
          resultValid <= 1'b1;
          frameVid <= curVid;
          frameDropped <= dropFlag;
          // tag decision only matters on ports that really send the frame
          if (dropFlag) begin
            egressMask <= {PORTS{1'b0}};
            egressTagMask <= {PORTS{1'b0}};
          end else if (dstKnown) begin
            egressMask <= {{(PORTS-1){1'b0}}, 1'b1} << dstPort; // R10
            egressTagMask <= tagMask & ({{(PORTS-1){1'b0}}, 1'b1} << dstPort); // R11
          end else begin
            egressMask <= floodMask; // R09 R15
            egressTagMask <= tagMask & floodMask; // R11
          end
          state <= S_DONE;
        end
        S_DONE: begin
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // root hello watchdog counted in age ticks
  reg [15:0] helloAge;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      helloMeta <= 1'b0;
      helloSync <= 1'b0;
      helloPrev <= 1'b0;
      helloAge <= 16'h0000;
      rootTimeout <= 1'b0;
    end else begin
      helloMeta <= rootHelloSeen;
      helloSync <= helloMeta;
      helloPrev <= helloSync;
      rootTimeout <= 1'b0;
      if (!treeStable || (helloSync && !helloPrev)) begin
        helloAge <= 16'h0000;
      end else if (ageTick) begin
        if (helloAge >= maxAgeTicks) begin
          rootTimeout <= 1'b1; // R16
          helloAge <= 16'h0000;
        end else begin
          helloAge <= helloAge + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/l2ffe_defines.vh ***
// shared constants of the layer-2 forwarding engine
// Function
// R01: untagged frame takes port default VLAN
// R02: tagged frame takes VLAN from tag
// R03: classify, learn, filter, then forward
// R04: unknown source pair inserted with port
// R05: known pair on other port rewritten
// R06: drop if source/destination port not forwarding
// R07: drop if source/destination address filtered; code compares the destination with the filters only for unicast frames
// R08: drop if destination port equals source
// R09: unknown unicast floods VLAN except source
// R10: known unicast goes to stored port
// R11: per-port tag insert or strip
// R12: aged entries removed from table
// R13: bridge protocol frames diverted to spanning tree
// R14: multicast filtered without destination lookup
// R15: multicast floods VLAN except source
// R16: no root hello in max age triggers reconfiguration
// R17: forward only through root/designated ports; code passes any forwarding port while treeStable is low
// R18: learning refreshes age, timeout removes
// R19: full table skips learning, still forwards
`ifndef L2FFE_DEFINES_VH
`define L2FFE_DEFINES_VH
`define L2FFE_BPDU_DA 48'h0180C2000000
`define L2FFE_ROLE_ROOT 2'h1
`define L2FFE_ROLE_DESIG 2'h2
`define L2FFE_AGE_TICK_NS 1000000
`define L2FFE_CLK_NS 20
`define L2FFE_AGE_TICK_CYC (`L2FFE_AGE_TICK_NS / `L2FFE_CLK_NS)
`define L2FFE_AGE_RESET 8'h00
`define L2FFE_MAXAGE_TICKS 16'd20000
`endif

// *** rtl/l2ffe_tick_div.v ***
// one-cycle enable pulse divider
`timescale 1ns/1ps
`default_nettype none
module l2ffe_tick_div #(
  parameter integer DIV = 50000
) (
  input wire core_clk,
  input wire rst,
  output reg tick
);
  reg [31:0] count;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count >= DIV - 1) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** tb/l2ffe_sva.sv ***
// checker of the forwarding engine timing and result relations
`timescale 1ns/1ps
`default_nettype none
module l2ffe_sva #(
  parameter integer PORTS = 8,
  parameter integer PW = 3
) (
  input wire core_clk,
  input wire rst,
  input wire frameValid,
  input wire busy,
  input wire [PW-1:0] rxPort,
  input wire [47:0] dstMac,
  input wire frameTagged,
  input wire [11:0] tagVid,
  input wire [PORTS-1:0] portForwarding,
  input wire [PORTS-1:0] portTaggedMember,
  input wire resultValid,
  input wire [PORTS-1:0] egressMask,
  input wire [PORTS-1:0] egressTagMask,
  input wire [11:0] frameVid,
  input wire frameDropped,
  input wire bpduValid,
  input wire [PW-1:0] bpduPort
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire take = frameValid && !busy;
  wire bpdu = dstMac == 48'h0180C2000000;
  chk_result_time: assert property (take && !bpdu |-> ##4 resultValid)
    else $error("result not four cycles after take");
  chk_bpdu_divert: assert property (take && bpdu |=> bpduValid && bpduPort == $past(rxPort))
    else $error("bridge frame not diverted");
  chk_bpdu_idle: assert property (take && bpdu |=> !busy && !resultValid)
    else $error("bridge frame entered switching path");
  chk_drop_empty: assert property (resultValid && frameDropped |-> egressMask == 0)
    else $error("dropped frame has egress ports");
  chk_no_source: assert property (resultValid |-> !egressMask[$past(rxPort, 4)])
    else $error("frame sent back to source port");
  chk_fwd_only: assert property (resultValid |-> (egressMask & ~portForwarding) == 0)
    else $error("frame sent to closed port");
  chk_tag_mask: assert property (resultValid |-> egressTagMask == (egressMask & portTaggedMember))
    else $error("egress tag mask wrong");
  chk_vid_tag: assert property (resultValid && $past(frameTagged, 4) |-> frameVid == $past(tagVid, 4))
    else $error("tagged frame vid wrong");
  chk_result_pulse: assert property (resultValid |=> !resultValid)
    else $error("result longer than one cycle");
endmodule
bind l2ffe_engine l2ffe_sva #(.PORTS(PORTS), .PW(PW)) chk (.core_clk(core_clk), .rst(rst),
  .frameValid(frameValid), .busy(busy), .rxPort(rxPort), .dstMac(dstMac),
  .frameTagged(frameTagged), .tagVid(tagVid), .portForwarding(portForwarding),
  .portTaggedMember(portTaggedMember), .resultValid(resultValid), .egressMask(egressMask),
  .egressTagMask(egressTagMask), .frameVid(frameVid), .frameDropped(frameDropped),
  .bpduValid(bpduValid), .bpduPort(bpduPort));
`default_nettype wire

// *** tb/l2ffe_stp_model.sv ***
// spanning tree controller and port state model
`timescale 1ns/1ps
`default_nettype none
module l2ffe_stp_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic helloEn,
  output logic [7:0] portForwarding,
  output logic [15:0] portRole,
  output logic treeStable,
  output logic rootHelloSeen
);
  logic [2:0] cnt;
  // port 5 blocked, port 0 root, rest designated
  assign portForwarding = 8'hDF;
  assign portRole = 16'hA2A9;
  assign treeStable = 1'b1;
  // hello every eight cycles while the root is alive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 3'h0;
      rootHelloSeen <= 1'b0;
    end else begin
      cnt <= cnt + 3'h1;
      rootHelloSeen <= helloEn && cnt == 3'h0;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_l2_frame_forwarding_engine.sv ***
// testbench of the layer-2 forwarding engine
`timescale 1ns/1ps
`default_nettype none
module tb_l2_frame_forwarding_engine;
  localparam logic [47:0] BPDU = 48'h0180C2000000;
  logic core_clk = 0, rst = 1, frameValid = 0, frameTagged = 0, helloEn = 1;
  logic [2:0] rxPort = 0;
  logic [47:0] dstMac = 0, srcMac = 0, fMac = 48'h0200000000AB, a, b, c;
  logic [11:0] tagVid = 0;
  logic [95:0] pdv = {12'h002, 12'h002, {6{12'h001}}}, pvi = {12'h002, 12'h002, {6{12'h001}}};
  logic [7:0] ptm = 8'h85, mem = 8'hFF, agePeriod = 8'h40;
  wire [7:0] fwd, egressMask, egressTagMask;
  wire [15:0] portRole;
  wire treeStable, rootHelloSeen, busy, resultValid, frameDropped, bpduValid, rootTimeout, skip;
  wire [2:0] bpduPort;
  wire [11:0] frameVid;
  int mismatches = 0, comparisons = 0, i;
  int tbl[logic [59:0]];
  logic skipSeen = 0;
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (skip) skipSeen <= 1'b1;
  l2ffe_stp_model stp (.core_clk(core_clk), .rst(rst), .helloEn(helloEn), .portForwarding(fwd),
    .portRole(portRole), .treeStable(treeStable), .rootHelloSeen(rootHelloSeen));
  l2ffe_engine #(.AGE_TICK_CYC(4)) dut (.core_clk(core_clk), .rst(rst), .frameValid(frameValid),
    .rxPort(rxPort), .dstMac(dstMac), .srcMac(srcMac), .frameTagged(frameTagged), .tagVid(tagVid),
    .portDefaultVid(pdv), .portForwarding(fwd), .portRole(portRole), .treeStable(treeStable),
    .portVlanId(pvi), .portVlanMember(mem), .portTaggedMember(ptm), .filterMac0(fMac),
    .filterMac1(48'h0), .filterEnable(2'h1), .agePeriod(agePeriod), .maxAgeTicks(16'h0004),
    .rootHelloSeen(rootHelloSeen), .busy(busy), .resultValid(resultValid),
    .egressMask(egressMask), .egressTagMask(egressTagMask), .frameVid(frameVid),
    .frameDropped(frameDropped), .bpduValid(bpduValid), .bpduPort(bpduPort),
    .rootTimeout(rootTimeout), .learnSkipped(skip));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input int rx, input logic [47:0] d, s, input logic tg, input logic [11:0] tv);
    int k, n;
    logic [11:0] v;
    logic [7:0] m;
    logic dr;
    v = tg ? tv : pdv[rx*12+:12];
    k = -1;
    if (d != BPDU) begin
      tbl[{v, s}] = rx;
      if (!d[40] && tbl.exists({v, d})) k = tbl[{v, d}];
    end
    m = 8'h00;
    for (n = 0; n < 8; n++) m[n] = (k < 0 ? pvi[n*12+:12] == v : n == k) && n != rx && fwd[n];
    dr = !fwd[rx] || s == fMac || d == fMac || (k >= 0 && (k == rx || !fwd[k]));
    if (dr) m = 8'h00;
    @(posedge core_clk);
    rxPort <= rx[2:0];
    dstMac <= d;
    srcMac <= s;
    frameTagged <= tg;
    tagVid <= tv;
    frameValid <= 1'b1;
    @(posedge core_clk);
    frameValid <= 1'b0;
    #1;
    for (n = 0; n < 8 && !(resultValid || bpduValid); n++) begin
      @(posedge core_clk);
      #1;
    end
    if (d == BPDU) begin
      check(bpduValid, 1);
      check(bpduPort, rx[2:0]);
    end else begin
      check(resultValid, 1);
      check(frameVid, v);
      check(frameDropped, dr);
      check(egressMask, m);
      check(egressTagMask, m & ptm);
    end
    repeat (2) @(posedge core_clk);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
  initial begin
    void'($urandom(32'hF396));
    a = {16'h0200, $urandom};
    b = {16'h0200, $urandom};
    c = {16'h0200, $urandom};
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    frame(1, b, a, 0, 0);
    frame(2, a, b, 1, 12'h001);
    frame(3, a, b, 0, 0);
    frame(1, b, a, 0, 0);
    frame(1, a, a, 0, 0);
    frame(5, b, c, 0, 0);
    frame(0, c, a, 0, 0);
    frame(0, b, fMac, 0, 0);
    frame(0, fMac, a, 0, 0);
    frame(2, 48'h01005E000001, a, 0, 0);
    frame(6, b, a, 0, 0);
    frame(0, b, a, 1, 12'h002);
    frame(3, BPDU, a, 0, 0);
    for (i = 0; i < 20; i++) frame($urandom % 5, {16'h0200, $urandom}, {16'h0200, $urandom}, 0, 0);
    check(skipSeen, tbl.num() > 16);
    repeat (400) @(posedge core_clk);
    tbl.delete();
    frame(2, a, b, 0, 0);
    helloEn <= 1'b0;
    for (i = 0; i < 100 && rootTimeout !== 1'b1; i++) @(posedge core_clk) #1;
    check(rootTimeout, 1);
    stop_test;
  end
endmodule
`default_nettype wire
